// File: pkg/pat_pkg.sv
`default_nettype none
package pat_pkg;
  localparam int unsigned NUM_WORDS  = 3;
  localparam int unsigned NUM_PHASES = 24;
  localparam int unsigned PORT_W     = 4;
  localparam int unsigned PHASE_W    = 5;
  // register byte offsets
  localparam logic [11:0] OFS_TBL0   = 12'h220;
  localparam logic [11:0] OFS_TBL1   = 12'h224;
  localparam logic [11:0] OFS_TBL2   = 12'h228;
  localparam logic [11:0] OFS_CTRL   = 12'h240;
  localparam logic [11:0] OFS_STAT   = 12'h244;
  // control / status fields
  localparam int unsigned CTRL_LOAD_BIT  = 0;
  localparam int unsigned CTRL_DOWN_BIT  = 1;
  localparam int unsigned CTRL_RUN_BIT   = 2;
  localparam int unsigned STAT_DIRTY_BIT = 16;
  // port id encoding
  localparam logic [3:0] PORT_UP      = 4'h0;
  localparam logic [3:0] PORT_MAX     = 4'h7;
  localparam logic [3:0] PORT_FIRST   = 4'h1;
  localparam logic [3:0] PORT_RSV_MAX = 4'hF;
  // reset table values
  localparam logic [31:0] RST_TBL0 = 32'h1765_4321;
  localparam logic [31:0] RST_TBL1 = 32'h2176_5432;
  localparam logic [31:0] RST_TBL2 = 32'h3217_6543;
  // hardware table load takes this many cycles
  localparam int unsigned LOAD_CYCLES = 3;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pat_req_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] port;
    logic [4:0] phase;
  } pat_grant_t;
endpackage
`default_nettype wire

// File: hdl/pat_arbiter.sv
// What this block does
// - each phase slot is a 4-bit port id granted during that period
// - id 0 is upstream, 1-7 downstream ports, 8-15 reserved
// - slots holding invalid ids are skipped at once, costing no period
// - phases 0-7 at 0x220, 8-15 at 0x224, 16-23 at 0x228, low nibble first
// - reset table cycles ports 1 to 7 in order starting at slot 0
// - dirty flag sets on table write, clears when hardware load completes
// - dirty flag always reads zero on downstream ports
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pat_arbiter
  import pat_pkg::*;
#(
  parameter logic [3:0] EGRESS_PORT = 4'h0
)
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // register port
  input  wire pat_pkg::pat_req_t req_i,
  output logic [31:0]           rdata_o,
  // arbitration
  input  wire logic [7:0]       port_valid_i,
  input  wire logic             period_done_i,
  output pat_pkg::pat_grant_t   grant_o,
  output logic                  dirty_o
);
  import pat_pkg::*;

  typedef enum logic [1:0] {
    LD_IDLE = 2'b01,
    LD_BUSY = 2'b10
  } pat_ld_t;

  logic [31:0] tbl [NUM_WORDS];
  logic [31:0] next_tbl [NUM_WORDS];
  logic [31:0] act [NUM_WORDS];
  logic [31:0] next_act [NUM_WORDS];
  logic        down;
  logic        next_down;
  logic        run;
  logic        next_run;
  logic        dirty;
  logic        next_dirty;
  logic        dirty_out;
  pat_ld_t     ld;
  pat_ld_t     next_ld;
  logic [1:0]  ld_cnt;
  logic [1:0]  next_ld_cnt;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [4:0]  phase;
  logic [4:0]  next_phase;
  pat_grant_t  grant;
  pat_grant_t  next_grant;

  function automatic logic [3:0] slot_port(input logic [31:0] w [NUM_WORDS],
                                           input logic [4:0] ph);
    logic [31:0] word;
    word = w[ph[4:3]];
    return word[{ph[2:0], 2'b00} +: 4];
  endfunction

  function automatic logic port_ok(input logic [3:0] id, input logic [7:0] v);
    port_ok = (id <= PORT_MAX) && v[id[2:0]] && (id != EGRESS_PORT);
  endfunction

  function automatic logic [4:0] inc_phase(input logic [4:0] ph);
    inc_phase = (ph == 5'(NUM_PHASES - 1)) ? 5'h00 : 5'(ph + 5'h01);
  endfunction

  // register decode and table load
  always_comb
  begin
    for (int i = 0; i < NUM_WORDS; i++)
    begin
      next_tbl[i] = tbl[i];
      next_act[i] = act[i];
    end
    next_down   = down;
    next_run    = run;
    next_dirty  = dirty;
    next_ld     = ld;
    next_ld_cnt = ld_cnt;
    next_rdata  = 32'h0000_0000;
    if (req_i.wr)
    begin
      case (req_i.addr)
        OFS_TBL0, OFS_TBL1, OFS_TBL2:
        begin
          next_tbl[req_i.addr[3:2]] = req_i.wdata;
          next_dirty = 1'b1;
        end
        OFS_CTRL:
        begin
          next_down = req_i.wdata[CTRL_DOWN_BIT];
          next_run  = req_i.wdata[CTRL_RUN_BIT];
          if (req_i.wdata[CTRL_LOAD_BIT])
          begin
            next_ld     = LD_BUSY;
            next_ld_cnt = 2'(LOAD_CYCLES - 1);
          end
        end
        default: ;
      endcase
    end
    if (req_i.rd)
    begin
      case (req_i.addr)
        OFS_TBL0, OFS_TBL1, OFS_TBL2: next_rdata = tbl[req_i.addr[3:2]];
        OFS_CTRL:
        begin
          next_rdata[CTRL_DOWN_BIT] = down;
          next_rdata[CTRL_RUN_BIT]  = run;
        end
        OFS_STAT: next_rdata[STAT_DIRTY_BIT] = dirty & ~down;
        default:  next_rdata = 32'h0000_0000;
      endcase
    end
    case (ld)
      LD_IDLE: ;
      LD_BUSY:
      begin
        if (ld_cnt == 2'h0)
        begin
          for (int i = 0; i < NUM_WORDS; i++)
            next_act[i] = tbl[i];
          next_ld = LD_IDLE;
          // a write in this same cycle keeps the flag set
          if (!(req_i.wr && (req_i.addr inside {OFS_TBL0, OFS_TBL1, OFS_TBL2})))
            next_dirty = 1'b0;
        end
        else
          next_ld_cnt = 2'(ld_cnt - 2'h1);
      end
      default: next_ld = LD_IDLE;
    endcase
  end

  // phase walk: skip invalid slots within the same cycle
  always_comb
  begin
    logic [4:0] p;
    logic       found;
    p          = phase;
    found      = 1'b0;
    next_phase = phase;
    next_grant = grant;
    if (!run)
      next_grant.valid = 1'b0;
    else if (period_done_i || !grant.valid)
    begin
      p = grant.valid ? inc_phase(phase) : phase;
      for (int k = 0; k < NUM_PHASES; k++)
      begin
        if (!found)
        begin
          if (port_ok(slot_port(act, p), port_valid_i))
            found = 1'b1;
          else
            p = inc_phase(p);
        end
      end
      next_grant.valid = found;
      next_grant.port  = slot_port(act, p);
      next_grant.phase = p;
      next_phase       = p;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tbl[0]  <= RST_TBL0;
      tbl[1]  <= RST_TBL1;
      tbl[2]  <= RST_TBL2;
      act[0]  <= RST_TBL0;
      act[1]  <= RST_TBL1;
      act[2]  <= RST_TBL2;
      down    <= 1'b0;
      run     <= 1'b0;
      dirty   <= 1'b0;
      dirty_out <= 1'b0;
      ld      <= LD_IDLE;
      ld_cnt  <= 2'h0;
      rdata   <= 32'h0000_0000;
      phase   <= 5'h00;
      grant   <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_WORDS; i++)
      begin
        tbl[i] <= next_tbl[i];
        act[i] <= next_act[i];
      end
      down   <= next_down;
      run    <= next_run;
      dirty  <= next_dirty;
      dirty_out <= next_dirty & ~next_down;
      ld     <= next_ld;
      ld_cnt <= next_ld_cnt;
      rdata  <= next_rdata;
      phase  <= next_phase;
      grant  <= next_grant;
    end
  end

  assign rdata_o = rdata;
  assign grant_o = grant;

  // masked flag kept in its own flop so the pin is registered
  assign dirty_o = dirty_out;
endmodule
`default_nettype wire

// File: testbench/pat_arbiter_properties.sv
`timescale 1ns/100ps
`default_nettype none
module pat_arbiter_chk
  import pat_pkg::*;
(
  // clock, bus
  input wire logic                clk_i,
  input wire logic                nrst_i,
  input wire pat_pkg::pat_req_t   req_i,
  input wire logic [31:0]         rdata_o,
  // arbitration
  input wire logic [7:0]          port_valid_i,
  input wire logic                period_done_i,
  input wire pat_pkg::pat_grant_t grant_o,
  input wire logic                dirty_o
);
  import pat_pkg::*;
  logic dn, next_dn, ctw, tbw, ldw;
  assign ctw = req_i.wr && req_i.addr == OFS_CTRL;
  assign tbw = req_i.wr && req_i.addr inside {OFS_TBL0, OFS_TBL1, OFS_TBL2};
  assign ldw = ctw && req_i.wdata[CTRL_LOAD_BIT];
  always_comb next_dn = ctw ? req_i.wdata[CTRL_DOWN_BIT] : dn;
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      dn <= 1'b0;
    else
      dn <= next_dn;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_rd; !$past(req_i.rd) |-> rdata_o == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("rdata not zero");
  property p_rsv; grant_o.valid |-> grant_o.port <= PORT_MAX; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved id granted");
  property p_skip; grant_o.valid && $changed(grant_o) |->
    |($past(port_valid_i) & (8'h01 << grant_o.port[2:0])); endproperty
  a_skip: assert property (p_skip) else $error("invalid port granted");
  property p_ph; grant_o.valid |-> grant_o.phase <= 5'h17; endproperty
  a_ph: assert property (p_ph) else $error("phase out of range");
  property p_hold; grant_o.valid && !period_done_i && !ctw |=> $stable(grant_o); endproperty
  a_hold: assert property (p_hold) else $error("grant moved early");
  property p_dset; tbw && !dn |=> dirty_o; endproperty
  a_dset: assert property (p_dset) else $error("dirty not set");
  property p_dclr; $fell(dirty_o) |-> dn || $past(ldw, 2) || $past(ldw, 3) ||
    $past(ldw, 4) || $past(ldw, 5); endproperty
  a_dclr: assert property (p_dclr) else $error("dirty cleared early");
  property p_ddn; dn |-> !dirty_o; endproperty
  a_ddn: assert property (p_ddn) else $error("dirty on downstream");
endmodule
bind pat_arbiter pat_arbiter_chk i_pat_arbiter_chk (.clk_i(clk_i), .nrst_i(nrst_i),
  .req_i(req_i), .rdata_o(rdata_o), .port_valid_i(port_valid_i),
  .period_done_i(period_done_i), .grant_o(grant_o), .dirty_o(dirty_o));
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pat_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  pat_req_t req = '0;
  logic [31:0] rdata, e;
  logic [31:0] rnd = 32'h0001_53AA;
  logic [31:0] exp_q[$];
  logic [7:0] pv = 8'hF6;
  logic pd = 1'b0;
  logic dirty;
  logic rd_q = 1'b0;
  pat_grant_t gnt;
  int error_cnt = 0;
  int compares = 0;
  int p = 0;
  always #10 clk_i = ~clk_i;
  pat_arbiter i_pat_arbiter (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req), .rdata_o(rdata),
    .port_valid_i(pv), .period_done_i(pd), .grant_o(gnt), .dirty_o(dirty));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // keep every nibble a legal downstream id
  function automatic logic [31:0] legal(input logic [31:0] v);
    for (int k = 0; k < 8; k++)
      legal[4*k +: 4] = 4'(v[4*k +: 4] % 7 + 1);
  endfunction
  function automatic int nx(input int s);
    for (int i = 0; i < 24; i++)
      if (pv[((s + i) % 24) % 7 + 1])
        return (s + i) % 24;
    return s;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x)
    begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic give_verdict;
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // read: d is the expected data
  task automatic bus(input logic [11:0] a, input logic [31:0] d, input logic w);
    @(posedge clk_i);
    req <= '{a, d, w, !w};
    if (!w)
      exp_q.push_back(d);
  endtask
  task automatic idle(input int n);
    @(posedge clk_i);
    req <= '0;
    repeat (n) @(posedge clk_i);
  endtask
  task automatic gchk(input int s);
    @(negedge clk_i);
    p = nx(s);
    chk({22'h0, gnt}, {22'h0, 1'b1, 4'(p % 7 + 1), 5'(p)});
  endtask
  always @(posedge clk_i) rd_q <= req.rd;
  always @(negedge clk_i)
    if (rd_q)
      chk(rdata, exp_q.pop_front());
  initial
  begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (int w = 0; w < 3; w++)
    begin
      for (int k = 0; k < 8; k++)
        e[4*k +: 4] = 4'((8*w + k) % 7 + 1);
      bus(OFS_TBL0 + 12'(4*w), e, 1'b0);
    end
    bus(12'h230, 32'h0, 1'b0);
    bus(OFS_STAT, 32'h0, 1'b0);
    bus(OFS_CTRL, 32'h5, 1'b1);
    idle(8);
    gchk(0);
    repeat (30)
    begin
      @(posedge clk_i);
      pd <= 1'b1;
      @(posedge clk_i);
      pd <= 1'b0;
      gchk((p + 1) % 24);
    end
    rnd = lfsr(rnd);
    e = legal(rnd);
    bus(OFS_TBL1, e, 1'b1);
    bus(OFS_TBL1, e, 1'b0);
    bus(OFS_STAT, 32'h0001_0000, 1'b0);
    idle(0);
    @(negedge clk_i);
    chk({31'h0, dirty}, 32'h1);
    bus(OFS_CTRL, 32'h5, 1'b1);
    idle(8);
    @(negedge clk_i);
    chk({31'h0, dirty}, 32'h0);
    bus(OFS_STAT, 32'h0, 1'b0);
    bus(OFS_TBL2, legal(lfsr(rnd)), 1'b1);
    bus(OFS_CTRL, 32'h6, 1'b1);
    bus(OFS_STAT, 32'h0, 1'b0);
    idle(4);
    @(negedge clk_i);
    chk({31'h0, dirty}, 32'h0);
    give_verdict();
  end
  initial
  begin
    repeat (3000) @(posedge clk_i);
    error_cnt++;
    give_verdict();
  end
endmodule
`default_nettype wire
